//--- bench/ogu_glyph_unpack_asserts.sv
// Port checker for the glyph unpacker
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------
// Checker
// ----------------------------------------------------------
module ogu_glyph_unpack_asserts (
  input wire logic ref_clk_in, // Clock
  input wire logic sys_rst_in, // Reset
  input wire logic progressive_en_in, // Repeat on
  input wire logic [1:0] glyph_format_in, // Depth
  input wire logic row_start_in, // Row pulse
  input wire logic line_start_in, // Line pulse
  input wire logic in_area_in, // Area flag
  input wire logic fetch_start_in, // Fetch pulse
  input wire logic onchip_data_ram_rd_out, // Read
  input wire logic onchip_data_ram_valid_in, // Data valid
  input wire logic pix_valid_out, // Pixel
  input wire logic [3:0] pix_index_out, // Index
  input wire logic pix_last_out, // Pixel 11
  input wire logic busy_out, // Busy
  input wire logic [3:0] glyph_line_out, // Row
  input wire logic line_repeat_out // Copy
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Accepted fetch, and a line pulse that row start does not override
  sequence s_take;
    fetch_start_in && !busy_out && glyph_format_in != 2'h3;
  endsequence
  sequence s_line;
    line_start_in && !row_start_in;
  endsequence
  AST_TAKE: assert property (
    s_take |=> onchip_data_ram_rd_out && busy_out)
    else $error("fetch not started");
  AST_BAD_FMT: assert property (
    fetch_start_in && !busy_out && glyph_format_in == 2'h3 |=> !busy_out)
    else $error("bad format taken");
  AST_RD_PULSE: assert property (
    onchip_data_ram_rd_out |=> !onchip_data_ram_rd_out)
    else $error("read too long");
  AST_EMIT: assert property (
    onchip_data_ram_valid_in && busy_out |-> ##[1:2] pix_valid_out)
    else $error("no pixel");
  AST_LAST: assert property (pix_last_out |-> pix_valid_out)
    else $error("lone last");
  AST_ONE_BIT: assert property (
    pix_valid_out && glyph_format_in == 2'h0 |-> pix_index_out[3:1] == 3'h0)
    else $error("wide index");
  AST_OUTSIDE: assert property (
    s_line ##0 !in_area_in |=> !line_repeat_out && $stable(glyph_line_out))
    else $error("outside line moved");
  AST_COPY: assert property (
    s_line ##0 (in_area_in && progressive_en_in && !line_repeat_out)
    |=> line_repeat_out && $stable(glyph_line_out))
    else $error("no copy");
  // Height is at least nine, so even a wrap to row 0 is a visible change
  AST_ADVANCE: assert property (
    s_line ##0 (in_area_in && (!progressive_en_in || line_repeat_out))
    |=> !line_repeat_out && glyph_line_out != $past(glyph_line_out))
    else $error("line not advanced");
  AST_ROW: assert property (
    row_start_in |=> glyph_line_out == 4'h0 && !line_repeat_out)
    else $error("row not cleared");
endmodule // ogu_glyph_unpack_asserts
bind ogu_glyph_unpack ogu_glyph_unpack_asserts u_chk (.ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in), .progressive_en_in(progressive_en_in),
  .glyph_format_in(glyph_format_in), .row_start_in(row_start_in),
  .line_start_in(line_start_in), .in_area_in(in_area_in),
  .fetch_start_in(fetch_start_in), .busy_out(busy_out),
  .onchip_data_ram_rd_out(onchip_data_ram_rd_out),
  .onchip_data_ram_valid_in(onchip_data_ram_valid_in),
  .pix_valid_out(pix_valid_out), .pix_index_out(pix_index_out),
  .pix_last_out(pix_last_out), .glyph_line_out(glyph_line_out),
  .line_repeat_out(line_repeat_out));
`default_nettype wire

//--- bench/ogu_glyph_unpack_tb.sv
// Self-checking bench for glyph unpack and line doubling
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------
// Bench top
// ----------------------------------------------------------
module ogu_glyph_unpack_tb;
  logic clk = 0, rst = 1, prog = 0, row = 0, lst = 0, area = 0, fetch = 0;
  logic [2:0] hsel = 3'h0;
  logic [1:0] fmt = 2'h0;
  logic [7:0] idx = 8'h00;
  wire [15:0] addr;
  wire [7:0] rdata;
  wire [3:0] pidx, gline;
  wire rd, rvalid, pv, plast, busy, rep;
  int error_cnt = 0, checks_done = 0, cur_line = 0;
  ogu_glyph_unpack dut (.ref_clk_in(clk), .sys_rst_in(rst),
    .progressive_en_in(prog), .glyph_height_select_in(hsel),
    .glyph_format_in(fmt), .glyph1bit_base_pointer_in(16'h1003),
    .glyph2bit_base_pointer_in(16'h2003),
    .glyph4bit_base_pointer_in(16'h3003), .glyph_index_in(idx),
    .row_start_in(row), .line_start_in(lst), .in_area_in(area),
    .fetch_start_in(fetch), .onchip_data_ram_addr_out(addr),
    .onchip_data_ram_rd_out(rd), .onchip_data_ram_data_in(rdata),
    .onchip_data_ram_valid_in(rvalid), .pix_valid_out(pv),
    .pix_index_out(pidx), .pix_last_out(plast), .busy_out(busy),
    .glyph_line_out(gline), .line_repeat_out(rep));
  // Slow RAM so the unpacker must wait for data
  ogu_ram_model #(.LAT(2)) ram (.clk_in(clk), .addr_in(addr), .rd_in(rd),
    .data_out(rdata), .valid_out(rvalid));
  always #2 clk = ~clk;
  // Pixel expected from base, glyph size rounded to bytes, bit 0 highest
  function automatic logic [3:0] exp_pix(int f, int hc, int ln, int id, int p);
    int bpp, off, a;
    logic [7:0] b;
    logic [3:0] v;
    bpp = 1 << f;
    off = (ln * 12 + p) * bpp;
    a = 'h1003 + 'h1000 * f + id * (((hc + 9) * 12 * bpp + 7) / 8) + off / 8;
    b = a[7:0] ^ 8'hA5;
    v = 4'h0;
    for (int k = 0; k < bpp; k++) v[k] = b[7 - off % 8 - k];
    return v;
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic set_line(int n);
    @(posedge clk); row <= 1'b1; prog <= 1'b0; area <= 1'b1;
    @(posedge clk); row <= 1'b0; lst <= (n != 0);
    repeat (n) @(posedge clk);
    lst <= 1'b0;
    #1 chk(gline, n[15:0]);
    cur_line = n;
  endtask
  task automatic pulse_line(logic p, logic a, int el, logic er);
    @(posedge clk); prog <= p; area <= a; lst <= 1'b1;
    @(posedge clk); lst <= 1'b0;
    #1 chk(gline, el[15:0]);
    chk(rep, er);
  endtask
  // A second fetch while busy must be ignored
  task automatic fetch_chk(int f, int hc, int id, logic poke);
    int n, t;
    n = 0;
    t = 0;
    @(posedge clk); fmt <= f[1:0]; idx <= id[7:0]; fetch <= 1'b1;
    @(posedge clk); fetch <= poke; idx <= idx + 8'h01;
    while (n < 12 && t < 100) begin
      @(posedge clk); fetch <= 1'b0;
      #1 t++;
      if (pv === 1'b1) begin
        chk(pidx, exp_pix(f, hc, cur_line, id, n));
        chk(plast, n == 11);
        n++;
      end
    end
    chk(n[15:0], 16'h000C);
  endtask
  task automatic t_double;
    @(posedge clk); hsel <= 3'h0;
    set_line(0);
    pulse_line(1, 1, 0, 1);
    pulse_line(1, 1, 1, 0);
    pulse_line(1, 0, 1, 0);
    pulse_line(1, 1, 1, 1);
    cur_line = 1;
    fetch_chk(2, 0, 0, 0);
    pulse_line(1, 1, 2, 0);
    for (int i = 3; i < 10; i++) pulse_line(0, 1, i % 9, 0);
  endtask
  // In 1-bit format the last row of a 9-line glyph ends on a free nibble and row 15 starts mid-byte
  task automatic t_formats;
    for (int f = 0; f < 3; f++)
      for (int hc = 0; hc < 8; hc += 7) begin
        @(posedge clk); hsel <= hc[2:0];
        set_line(hc != 0 ? 15 : 8);
        fetch_chk(f, hc, 5, f == 1);
      end
  endtask
  task automatic t_refuse;
    @(posedge clk); fmt <= 2'h3; fetch <= 1'b1;
    @(posedge clk); fetch <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(busy, 1'b0);
  endtask
  // Reset in mid-run with a repeat pending and a fetch under way
  task automatic t_reset;
    @(posedge clk); prog <= 1'b1; area <= 1'b1; lst <= 1'b1;
    @(posedge clk); lst <= 1'b0; fmt <= 2'h0; fetch <= 1'b1;
    @(posedge clk); fetch <= 1'b0; rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(gline, 16'h0000);
    chk(rep, 1'b0);
    chk({pv, busy}, 2'h0);
    pulse_line(1, 1, 0, 1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_double;
    t_formats;
    t_refuse;
    t_reset;
    give_verdict;
  end
  initial begin
    #40000;
    error_cnt++;
    give_verdict;
  end
endmodule // ogu_glyph_unpack_tb
`default_nettype wire

//--- bench/ogu_ram_model.sv
// Behavioural on-chip data RAM with fixed read latency
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------
// RAM model
// ----------------------------------------------------------
module ogu_ram_model #(parameter int LAT = 2) (
  input wire logic clk_in, // Clock
  input wire logic [15:0] addr_in, // Byte address
  input wire logic rd_in, // Read strobe
  output logic [7:0] data_out, // Read data
  output logic valid_out // Data valid pulse
);
  logic [LAT-1:0] pipe_q = '0;
  logic [15:0] addr_q = 16'h0000;
  // Byte is a pattern of its address; idle bus shows the inverse
  always @(posedge clk_in) begin
    pipe_q <= {pipe_q[LAT-2:0], rd_in};
    if (rd_in) addr_q <= addr_in;
  end
  assign valid_out = pipe_q[LAT-1];
  assign data_out = (addr_q[7:0] ^ 8'hA5) ^ {8{!valid_out}};
endmodule // ogu_ram_model
`default_nettype wire

//--- hw/ogu_glyph_unpack.v
// Downloadable glyph fetcher and pixel unpacker with line doubling
`timescale 1ns/100ps
`default_nettype none
`include "ogu_regs.vh"


module ogu_glyph_unpack (
  input wire ref_clk_in, // 250 MHz clock
  input wire sys_rst_in, // Synchronous reset, active high
  input wire progressive_en_in, // Progressive scan enable
  input wire [2:0] glyph_height_select_in, // Glyph height code
  input wire [1:0] glyph_format_in, // Pixel depth format
  input wire [15:0] glyph1bit_base_pointer_in, // 1-bit area base
  input wire [15:0] glyph2bit_base_pointer_in, // 2-bit area base
  input wire [15:0] glyph4bit_base_pointer_in, // 4-bit area base
  input wire [7:0] glyph_index_in, // Glyph number in its area
  input wire row_start_in, // Pulse, first line of glyph row
  input wire line_start_in, // Pulse, start of each output line
  input wire in_area_in, // Line inside character display area
  input wire fetch_start_in, // Pulse, unpack one glyph line
  output wire [15:0] onchip_data_ram_addr_out, // RAM byte address
  output wire onchip_data_ram_rd_out, // RAM read strobe
  input wire [7:0] onchip_data_ram_data_in, // RAM read data
  input wire onchip_data_ram_valid_in, // RAM data valid pulse
  output wire pix_valid_out, // Pulse, colour index valid
  output wire [3:0] pix_index_out, // Colour vector index
  output wire pix_last_out, // Pulse with pixel 11
  output wire busy_out, // Fetch in progress
  output wire [3:0] glyph_line_out, // Current glyph pixel row
  output wire line_repeat_out // Current line is a repeat
);

  localparam ST_IDLE = 2'h0;
  localparam ST_REQ = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_EMIT = 2'h3;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Bits for a count of glyph lines; depth scales by shifting
  function [10:0] ogu_bits;
    input [4:0] lines;
    input [1:0] fmt;
    reg [10:0] base_bits;
    begin
      base_bits = {6'h00, lines} * {3'h0, `OGU_GLYPH_WIDTH};
      case (fmt)
        `OGU_FMT_2BIT: ogu_bits = base_bits << 1;
        `OGU_FMT_4BIT: ogu_bits = base_bits << 2;
        default: ogu_bits = base_bits;
      endcase
    end
  endfunction

  // Bits per pixel of a format
  function [3:0] ogu_bpp;
    input [1:0] fmt;
    begin
      case (fmt)
        `OGU_FMT_2BIT: ogu_bpp = 4'h2;
        `OGU_FMT_4BIT: ogu_bpp = 4'h4;
        default: ogu_bpp = 4'h1;
      endcase
    end
  endfunction

  reg [1:0] state_q;
  reg [1:0] fmt_q;
  reg [15:0] addr_q;
  reg [7:0] sh_q;
  reg [3:0] left_q;
  reg [3:0] pcnt_q;
  reg skip_q;
  reg [3:0] pix_q;
  reg pvalid_q;
  reg plast_q;
  wire [3:0] gline;
  wire [4:0] lines;
  wire [10:0] gbytes;
  wire [10:0] loff_bits;
  reg [15:0] base_sel;
  wire [15:0] start_addr;
  wire [3:0] bpp;
  reg [3:0] pix_val;

  // --------------------------------------------------------------
  // Line counter and repetition
  // --------------------------------------------------------------
  ogu_line_double u_line (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .progressive_en_in(progressive_en_in),
    .glyph_height_select_in(glyph_height_select_in),
    .row_start_in(row_start_in),
    .line_start_in(line_start_in),
    .in_area_in(in_area_in),
    .glyph_line_out(gline),
    .line_repeat_out(line_repeat_out)
  );

  // --------------------------------------------------------------
  // Address generation
  // --------------------------------------------------------------
  assign lines = {1'b0, `OGU_HEIGHT_MIN} + {2'h0, glyph_height_select_in};
  // Round up so each glyph begins on its own byte
  assign gbytes = (ogu_bits(lines, glyph_format_in) + `OGU_ROUND_UP)
    >> `OGU_BYTE_SHIFT;
  assign loff_bits = ogu_bits({1'b0, gline}, glyph_format_in);

  // Each depth lives in its own area of the data RAM
  always @* begin
    case (glyph_format_in)
      `OGU_FMT_2BIT: base_sel = glyph2bit_base_pointer_in;
      `OGU_FMT_4BIT: base_sel = glyph4bit_base_pointer_in;
      default: base_sel = glyph1bit_base_pointer_in;
    endcase
  end

  // Index times bytes fits 8+7 bits; the sum wraps at 64 KiB
  assign start_addr = base_sel
    + ({8'h00, glyph_index_in} * {5'h00, gbytes})
    + {8'h00, loff_bits[10:3]};

  // --------------------------------------------------------------
  // Pixel extraction
  // --------------------------------------------------------------
  assign bpp = ogu_bpp(fmt_q);

  // Stored bit 0 sits highest, so the top bits are reversed
  always @* begin
    case (fmt_q)
      `OGU_FMT_2BIT: pix_val = {2'h0, sh_q[6], sh_q[7]};
      `OGU_FMT_4BIT: pix_val = {sh_q[4], sh_q[5], sh_q[6], sh_q[7]};
      default: pix_val = {3'h0, sh_q[7]};
    endcase
  end

  // --------------------------------------------------------------
  // Fetch sequencer
  // --------------------------------------------------------------
  // Pixels leave one per clock once a byte lands; the caller must
  // not restart a fetch while busy, a restart then is ignored.
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      fmt_q <= `OGU_FMT_1BIT;
      addr_q <= 16'h0000;
      sh_q <= 8'h00;
      left_q <= 4'h0;
      pcnt_q <= 4'h0;
      skip_q <= 1'b0;
      pix_q <= 4'h0;
      pvalid_q <= 1'b0;
      plast_q <= 1'b0;
    end else begin
      pvalid_q <= 1'b0;
      plast_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (fetch_start_in && glyph_format_in != `OGU_FMT_BAD) begin
            fmt_q <= glyph_format_in;
            addr_q <= start_addr;
            skip_q <= loff_bits[2];
            pcnt_q <= 4'h0;
            state_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (onchip_data_ram_valid_in) begin
            // Odd 1-bit lines start in the low nibble of a shared byte
            if (skip_q) begin
              sh_q <= onchip_data_ram_data_in << `OGU_HALF_BYTE;
              left_q <= `OGU_HALF_BYTE;
            end else begin
              sh_q <= onchip_data_ram_data_in;
              left_q <= `OGU_BYTE_BITS;
            end
            skip_q <= 1'b0;
            state_q <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          pix_q <= pix_val;
          pvalid_q <= 1'b1;
          sh_q <= sh_q << bpp;
          left_q <= left_q - bpp;
          pcnt_q <= pcnt_q + 4'h1;
          if (pcnt_q == `OGU_LAST_PIXEL) begin
            // Remaining bits of the byte, such as a free nibble, drop
            plast_q <= 1'b1;
            state_q <= ST_IDLE;
          end else if (left_q == bpp) begin
            addr_q <= addr_q + 16'h0001;
            state_q <= ST_REQ;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign onchip_data_ram_addr_out = addr_q;
  assign onchip_data_ram_rd_out = (state_q == ST_REQ);
  assign busy_out = (state_q != ST_IDLE);
  assign pix_valid_out = pvalid_q;
  assign pix_index_out = pix_q;
  assign pix_last_out = plast_q;
  assign glyph_line_out = gline;

endmodule // ogu_glyph_unpack
`default_nettype wire

//--- hw/ogu_line_double.v
// Glyph line counter with progressive scan line repetition
`timescale 1ns/100ps
`default_nettype none
`include "ogu_regs.vh"

module ogu_line_double (
  input wire ref_clk_in, // Pixel domain clock
  input wire sys_rst_in, // Synchronous reset, active high
  input wire progressive_en_in, // 1 repeats each area line
  input wire [2:0] glyph_height_select_in, // 9 to 16 lines
  input wire row_start_in, // Pulse, first line of a glyph row
  input wire line_start_in, // Pulse, each output display line
  input wire in_area_in, // Line lies in character display area
  output wire [3:0] glyph_line_out, // Current glyph pixel row
  output wire line_repeat_out // Current line is the repeat copy
);

  reg [3:0] line_q;
  reg [3:0] line_d;
  reg rep_q;
  reg rep_d;
  wire [3:0] last_line;

  // --------------------------------------------------------------
  // Line advance
  // --------------------------------------------------------------
  assign last_line = `OGU_HEIGHT_LAST_MIN
    + {1'b0, glyph_height_select_in};

  // Outside the display area the counter freezes, so stray lines
  // above a row never bump it and nothing is doubled there.
  always @* begin
    line_d = line_q;
    rep_d = rep_q;
    if (row_start_in) begin
      line_d = 4'h0;
      rep_d = 1'b0;
    end else if (line_start_in) begin
      if (!in_area_in) begin
        rep_d = 1'b0;
      end else if (progressive_en_in && !rep_q) begin
        rep_d = 1'b1;
      end else begin
        rep_d = 1'b0;
        line_d = (line_q >= last_line) ? 4'h0 : line_q + 4'h1;
      end
    end
  end

  // State registers
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      line_q <= 4'h0;
      rep_q <= 1'b0;
    end else begin
      line_q <= line_d;
      rep_q <= rep_d;
    end
  end

  assign glyph_line_out = line_q;
  assign line_repeat_out = rep_q;

endmodule // ogu_line_double
`default_nettype wire

//--- hw/ogu_regs.vh
// Constants shared by the glyph unpack and line doubling logic
`ifndef OGU_REGS_VH
`define OGU_REGS_VH

// ----------------------------------------------------------------
// Pixel depth formats
// ----------------------------------------------------------------
`define OGU_FMT_1BIT 2'h0
`define OGU_FMT_2BIT 2'h1
`define OGU_FMT_4BIT 2'h2
`define OGU_FMT_BAD 2'h3

// ----------------------------------------------------------------
// Glyph geometry
// ----------------------------------------------------------------
`define OGU_HEIGHT_MIN 4'h9
`define OGU_HEIGHT_LAST_MIN 4'h8
`define OGU_GLYPH_WIDTH 8'h0C
`define OGU_LAST_PIXEL 4'hB
`define OGU_BYTE_BITS 4'h8
`define OGU_HALF_BYTE 4'h4
`define OGU_ROUND_UP 11'h007
`define OGU_BYTE_SHIFT 4'h3

`endif
